// file: src/lecc_consts.svh
`ifndef LECC_CONSTS_SVH
`define LECC_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LECC_OFS_PAR_HI      8'h05
`define LECC_OFS_PAR_LO      8'h06
`define LECC_OFS_WD_CTRL     8'h07
`define LECC_OFS_BUS_CTRL    8'h08

// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define LECC_RST_PAR_HI      8'h01
`define LECC_RST_PAR_LO      8'h00
`define LECC_RST_WD_TIMEOUT  7'h7F
`define LECC_RST_WD_OFF      1'h0
`define LECC_RST_BLOCK_WR    1'h0
`define LECC_RST_SDA_HOLD    3'h1
`define LECC_RST_FILTER      4'hC
`define LECC_BIT_WD_OFF      0
`define LECC_BIT_BLOCK_WR    7

// ----------------------------------------
// Timing
// ----------------------------------------
`define LECC_CLK_PERIOD_NS   16'h0014
`define LECC_CLK_KHZ         32'h0000C350
`define LECC_WD_UNIT_MS      32'h00000002
`define LECC_SDA_HOLD_STEP_NS 16'h0032
`define LECC_FILTER_STEP_NS  16'h0005
`define LECC_HOLD_TAPS       32

`endif

// file: src/lecc_link_cfg.sv
`timescale 1ns/1ps
`include "lecc_consts.svh"

// How it works
// - Each port flags parity fault once its error count reaches the 16-bit limit.
// - High limit byte holds bits 15..8, resets to 0x01, read/write.
// - Low limit byte holds bits 7..0, resets to 0x00, read/write.
// - Enabled watchdog aborts any control-channel transaction exceeding the timeout.
// - Timeout field bits 7..1 counts 2 ms units, resets to 0x7F.
// - Bit 0 set disables the watchdog; resets to enabled.
// - Control bit 7 set rejects far-side writes to our own registers.
// - Far-side accesses to local bus targets still pass when blocking.
// - Bits 6..4 set SDA input hold after SCL in 50 ns steps, reset 1.
// - Bits 3..0 set widest rejected SCL/SDA glitch in 5 ns steps, reset 0xC.
// - Parity errors are counted only while the checker enable is high.
module lecc_link_cfg #(
    parameter int NUM_PORTS   = 4,
    parameter int TICK_CYCLES = `LECC_WD_UNIT_MS * `LECC_CLK_KHZ
) (
    input  wire logic                 clk_in,
    input  wire logic                 rst_in,
    input  wire lecc_pkg::lecc_req_t  reg_req_in,
    output logic [7:0]                reg_rdata_out,
    output logic                      write_rejected_out,
    input  wire lecc_pkg::lecc_req_t  tgt_req_in,
    output lecc_pkg::lecc_req_t       tgt_req_out,
    input  wire logic                 parity_check_en_in,
    input  wire logic [NUM_PORTS-1:0] parity_err_in,
    input  wire logic [NUM_PORTS-1:0] parity_clear_in,
    output logic [NUM_PORTS-1:0]      parity_flag_out,
    input  wire logic                 cc_start_in,
    input  wire logic                 cc_done_in,
    output logic                      cc_abort_out,
    input  wire logic                 scl_pin_in,
    input  wire logic                 sda_pin_in,
    output logic                      scl_filt_out,
    output logic                      sda_filt_out
);
    import lecc_pkg::*;

    if (NUM_PORTS < 1 || TICK_CYCLES < 2) begin : g_chk
        $error("lecc_link_cfg: bad NUM_PORTS or TICK_CYCLES");
    end

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [7:0]     limit_hi;
    logic [7:0]     limit_lo;
    logic [6:0]     wd_timeout;
    logic           wd_off;
    logic           block_remote_wr;
    logic [2:0]     sda_hold;
    logic [3:0]     filter_depth;
    logic           local_wr;

    assign local_wr = reg_req_in.wr && !(reg_req_in.remote && block_remote_wr);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            limit_hi        <= `LECC_RST_PAR_HI;
            limit_lo        <= `LECC_RST_PAR_LO;
            wd_timeout      <= `LECC_RST_WD_TIMEOUT;
            wd_off          <= `LECC_RST_WD_OFF;
            block_remote_wr <= `LECC_RST_BLOCK_WR;
            sda_hold        <= `LECC_RST_SDA_HOLD;
            filter_depth    <= `LECC_RST_FILTER;
        end else if (local_wr) begin
            unique case (reg_req_in.addr)
                `LECC_OFS_PAR_HI: limit_hi <= reg_req_in.wdata;
                `LECC_OFS_PAR_LO: limit_lo <= reg_req_in.wdata;
                `LECC_OFS_WD_CTRL: begin
                    wd_timeout <= reg_req_in.wdata[7:1];
                    wd_off     <= reg_req_in.wdata[`LECC_BIT_WD_OFF];
                end
                `LECC_OFS_BUS_CTRL: begin
                    block_remote_wr <= reg_req_in.wdata[`LECC_BIT_BLOCK_WR];
                    sda_hold        <= reg_req_in.wdata[6:4];
                    filter_depth    <= reg_req_in.wdata[3:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Unmapped offsets read as zero
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_req_in.rd) begin
            unique case (reg_req_in.addr)
                `LECC_OFS_PAR_HI:   reg_rdata_out <= limit_hi;
                `LECC_OFS_PAR_LO:   reg_rdata_out <= limit_lo;
                `LECC_OFS_WD_CTRL:  reg_rdata_out <= {wd_timeout, wd_off};
                `LECC_OFS_BUS_CTRL: reg_rdata_out <= {block_remote_wr, sda_hold, filter_depth};
                default:            reg_rdata_out <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            write_rejected_out <= 1'b0;
        end else begin
            write_rejected_out <= reg_req_in.wr && reg_req_in.remote && block_remote_wr;
        end
    end

    // Target traffic never sees the block bit
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tgt_req_out <= '0;
        end else begin
            tgt_req_out <= tgt_req_in;
        end
    end

    // ----------------------------------------
    // Parity error counters
    // ----------------------------------------
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        lecc_port_counter #(
            .CNT_W (16)
        ) u_cnt (
            .clk_in        (clk_in),
            .rst_in        (rst_in),
            .check_en_in   (parity_check_en_in),
            .parity_err_in (parity_err_in[p]),
            .clear_in      (parity_clear_in[p]),
            .limit_in      ({limit_hi, limit_lo}),
            .flag_out      (parity_flag_out[p])
        );
    end

    // ----------------------------------------
    // Control-channel watchdog
    // ----------------------------------------
    lecc_wd_state_t wd_state;
    logic [31:0]    tick_cnt;
    logic           tick;
    logic [6:0]     unit_cnt;
    logic           expire;

    assign tick   = (tick_cnt == 32'(TICK_CYCLES - 1));
    // A zero timeout is left to software to avoid; it expires on the first tick
    assign expire = tick && ((unit_cnt + 7'h01) >= wd_timeout);

    // Divider restarts with each transaction so the timeout is exact
    always_ff @(posedge clk_in) begin
        if (rst_in || cc_start_in || wd_state != LECC_WD_RUN) begin
            tick_cnt <= 32'h00000000;
        end else if (tick) begin
            tick_cnt <= 32'h00000000;
        end else begin
            tick_cnt <= tick_cnt + 32'h00000001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || cc_start_in) begin
            unit_cnt <= 7'h00;
        end else if (wd_state == LECC_WD_RUN && tick) begin
            unit_cnt <= unit_cnt + 7'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wd_state <= LECC_WD_IDLE;
        end else begin
            unique case (wd_state)
                LECC_WD_IDLE: begin
                    if (cc_start_in && !wd_off) begin
                        wd_state <= LECC_WD_RUN;
                    end
                end
                LECC_WD_RUN: begin
                    if (cc_start_in) begin
                        wd_state <= LECC_WD_RUN;
                    end else if (cc_done_in || wd_off) begin
                        wd_state <= LECC_WD_IDLE;
                    end else if (expire) begin
                        wd_state <= LECC_WD_ABORT;
                    end
                end
                LECC_WD_ABORT: wd_state <= LECC_WD_IDLE;
                default:       wd_state <= LECC_WD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cc_abort_out <= 1'b0;
        end else begin
            cc_abort_out <= (wd_state == LECC_WD_RUN) && expire && !cc_start_in
                            && !cc_done_in && !wd_off;
        end
    end

    // ----------------------------------------
    // SCL/SDA conditioning
    // ----------------------------------------
    logic [1:0]  pin_meta;
    logic [1:0]  pin_sync;
    logic [1:0]  line_filt;
    logic [15:0] filter_cyc;
    logic [15:0] hold_cyc;
    logic [`LECC_HOLD_TAPS-1:0] sda_taps;

    // Round up so no pulse at the programmed width slips through
    assign filter_cyc = 16'(({12'h000, filter_depth} * `LECC_FILTER_STEP_NS
                        + `LECC_CLK_PERIOD_NS - 16'h0001) / `LECC_CLK_PERIOD_NS);
    assign hold_cyc   = 16'(({13'h0000, sda_hold} * `LECC_SDA_HOLD_STEP_NS
                        + `LECC_CLK_PERIOD_NS - 16'h0001) / `LECC_CLK_PERIOD_NS);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pin_meta <= 2'h3;
            pin_sync <= 2'h3;
        end else begin
            pin_meta <= {sda_pin_in, scl_pin_in};
            pin_sync <= pin_meta;
        end
    end

    for (genvar l = 0; l < 2; l++) begin : g_filt
        logic [15:0] stable_cnt;
        always_ff @(posedge clk_in) begin
            if (rst_in) begin
                stable_cnt   <= 16'h0000;
                line_filt[l] <= 1'b1;
            end else if (pin_sync[l] == line_filt[l]) begin
                stable_cnt <= 16'h0000;
            end else if (stable_cnt >= filter_cyc) begin
                stable_cnt   <= 16'h0000;
                line_filt[l] <= pin_sync[l];
            end else begin
                stable_cnt <= stable_cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sda_taps     <= '1;
            scl_filt_out <= 1'b1;
            sda_filt_out <= 1'b1;
        end else begin
            sda_taps     <= {sda_taps[`LECC_HOLD_TAPS-2:0], line_filt[1]};
            scl_filt_out <= line_filt[0];
            sda_filt_out <= (hold_cyc == 16'h0000) ? line_filt[1]
                            : sda_taps[5'(hold_cyc - 16'h0001)];
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_HI_RESET: assert property (@(posedge clk_in)
        $past(rst_in) |-> (limit_hi == 8'h01 && limit_lo == 8'h00)) else $error("bad limit reset");
    AST_LO_WRITE: assert property (@(posedge clk_in) disable iff (rst_in)
        (local_wr && reg_req_in.addr == 8'h06) |=> limit_lo == $past(reg_req_in.wdata))
        else $error("low byte write lost");
    AST_WD_RESET: assert property (@(posedge clk_in)
        $past(rst_in) |-> ({wd_timeout, wd_off} == 8'hFE)) else $error("bad watchdog reset");
    AST_ABORT_ENABLED: assert property (@(posedge clk_in) disable iff (rst_in)
        cc_abort_out |-> $past(!wd_off && wd_state == LECC_WD_RUN)) else $error("abort while off");
    AST_ABORT_DUE: assert property (@(posedge clk_in) disable iff (rst_in)
        (wd_state == LECC_WD_RUN && expire && !cc_start_in && !cc_done_in && !wd_off)
        |=> cc_abort_out ##1 wd_state == LECC_WD_IDLE) else $error("missed timeout abort");
    AST_RESTART: assert property (@(posedge clk_in) disable iff (rst_in)
        cc_start_in |=> (unit_cnt == 7'h00 && tick_cnt == 32'h00000000)) else $error("no restart");
    AST_REMOTE_BLOCK: assert property (@(posedge clk_in) disable iff (rst_in)
        (reg_req_in.wr && reg_req_in.remote && block_remote_wr)
        |=> ($stable({limit_hi, limit_lo, wd_timeout, wd_off}) && write_rejected_out))
        else $error("remote write not blocked");
    AST_TGT_PASS: assert property (@(posedge clk_in) disable iff (rst_in)
        1'b1 |=> tgt_req_out == $past(tgt_req_in)) else $error("target access altered");
    AST_GLITCH: assert property (@(posedge clk_in) disable iff (rst_in)
        $changed(line_filt[0]) |-> $past(pin_sync[0]) == line_filt[0]) else $error("glitch passed");

    COV_ABORT: cover property (@(posedge clk_in) disable iff (rst_in) cc_abort_out);
    COV_REJECT: cover property (@(posedge clk_in) disable iff (rst_in) write_rejected_out);
    COV_SCL: cover property (@(posedge clk_in) disable iff (rst_in) $fell(scl_filt_out));
endmodule : lecc_link_cfg

// file: src/lecc_pkg.sv
package lecc_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       remote;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lecc_req_t;

    typedef enum logic [1:0] {
        LECC_WD_IDLE  = 2'b00,
        LECC_WD_RUN   = 2'b01,
        LECC_WD_ABORT = 2'b11
    } lecc_wd_state_t;
endpackage : lecc_pkg

// file: src/lecc_port_counter.sv
`timescale 1ns/1ps
module lecc_port_counter #(
    parameter int CNT_W = 16
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             check_en_in,
    input  wire logic             parity_err_in,
    input  wire logic             clear_in,
    input  wire logic [CNT_W-1:0] limit_in,
    output logic                  flag_out
);
    logic [CNT_W-1:0] count;
    logic             set_flag;

    if (CNT_W < 1) begin : g_chk
        $error("lecc_port_counter: CNT_W must be positive");
    end

    // Saturate so a long error burst never wraps below the limit
    always_ff @(posedge clk_in) begin
        if (rst_in || clear_in) begin
            count <= '0;
        end else if (check_en_in && parity_err_in && (count != '1)) begin
            count <= count + 1'b1;
        end
    end

    // Clear empties the count too, so the stale level must not re-set the flag
    assign set_flag = check_en_in && !clear_in && (count >= limit_in);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flag_out <= 1'b0;
        end else begin
            flag_out <= set_flag || (flag_out && !clear_in);
        end
    end

    AST_FLAG_SET: assert property (@(posedge clk_in) disable iff (rst_in)
        set_flag |=> flag_out) else $error("parity flag not set at limit");
    AST_COUNT_GATED: assert property (@(posedge clk_in) disable iff (rst_in)
        (!check_en_in && !clear_in) |=> $stable(count)) else $error("counted while disabled");
    AST_FLAG_CLEAR: assert property (@(posedge clk_in) disable iff (rst_in)
        clear_in |=> !flag_out) else $error("parity flag survived clear");
    COV_FLAG: cover property (@(posedge clk_in) disable iff (rst_in) $rose(flag_out));
endmodule : lecc_port_counter

// file: tb/lecc_remote_model.sv
`timescale 1ns/1ps
module lecc_remote_model (
    input  wire logic           clk_in,
    input  wire logic           abort_in,
    output logic                cc_start_out,
    output logic                cc_done_out,
    output lecc_pkg::lecc_req_t tgt_req_out
);
    import lecc_pkg::*;
    initial begin
        cc_start_out = 1'b0;
        cc_done_out = 1'b0;
        tgt_req_out = '0;
    end
    // ----------------------------------------
    // Control-channel transaction
    // ----------------------------------------
    // Done after len cycles (0: never), second start at rs (0: none)
    task automatic run(input int len, input int rs, output int seen);
        seen = -1;
        @(posedge clk_in);
        cc_start_out <= 1'b1;
        for (int k = 1; k <= 1100 && seen < 0; k++) begin
            @(posedge clk_in);
            cc_start_out <= (k == rs);
            cc_done_out <= (k == len);
            #1 if (abort_in === 1'b1) seen = k;
        end
        @(posedge clk_in);
        cc_start_out <= 1'b0;
        cc_done_out <= 1'b0;
    endtask : run
    // ----------------------------------------
    // Local-bus target access
    // ----------------------------------------
    // Released lines clear wr/rd and invert addr and wdata; remote keeps its old value
    task automatic target(input lecc_req_t r);
        @(posedge clk_in);
        tgt_req_out <= r;
        @(posedge clk_in);
        tgt_req_out <= '{1'b0, 1'b0, r.remote, ~r.addr, ~r.wdata};
    endtask : target
endmodule : lecc_remote_model

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import lecc_pkg::*;
    localparam int NP = 4;
    localparam int TK = 8;
    logic            clk_in, rst_in, rej, en, cc_start, cc_done, abort;
    logic            scl, sda, scl_f, sda_f, rej_seen;
    lecc_req_t       req, tgt_in, tgt_out, r;
    logic [7:0]      rdata, d;
    logic [NP-1:0]   perr, pclr, pflag, fl;
    int              failures = 0, samples_checked = 0, cycles = 0;
    int              m [0:255];
    int              cnt [NP];
    int              seen, lim, p, t;
    int              f [2];

    lecc_link_cfg #(.NUM_PORTS(NP), .TICK_CYCLES(TK)) i_lecc_link_cfg (
        .clk_in(clk_in), .rst_in(rst_in), .reg_req_in(req), .reg_rdata_out(rdata),
        .write_rejected_out(rej), .tgt_req_in(tgt_in), .tgt_req_out(tgt_out),
        .parity_check_en_in(en), .parity_err_in(perr), .parity_clear_in(pclr),
        .parity_flag_out(pflag), .cc_start_in(cc_start), .cc_done_in(cc_done),
        .cc_abort_out(abort), .scl_pin_in(scl), .sda_pin_in(sda),
        .scl_filt_out(scl_f), .sda_filt_out(sda_f));
    lecc_remote_model i_lecc_remote_model (.clk_in(clk_in), .abort_in(abort),
        .cc_start_out(cc_start), .cc_done_out(cc_done), .tgt_req_out(tgt_in));

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    // Longest path is a few thousand cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a);
        @(posedge clk_in);
        req <= '{1'b0, 1'b1, 1'b0, a, 8'h00};
        @(posedge clk_in);
        req <= '0;
        #1 chk("rdata", m[a], 32'(rdata));
    endtask : rd
    // Model keeps the shadow copy and predicts the refusal
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic rem);
        logic e;
        e = rem && m[8][7];
        @(posedge clk_in);
        req <= '{1'b1, 1'b0, rem, a, v};
        @(posedge clk_in);
        req <= '0;
        #1 chk("rejected", 32'(e), 32'(rej));
        if (!e && a >= 8'h05 && a <= 8'h08) m[a] = v;
    endtask : wr
    task automatic perr_step(input int q, input logic clr);
        @(posedge clk_in);
        perr <= clr ? '0 : NP'(1) << q;
        pclr <= clr ? NP'(1) << q : '0;
        @(posedge clk_in);
        perr <= '0;
        pclr <= '0;
        if (clr) begin
            cnt[q] = 0;
            fl[q] = 1'b0;
        end else if (en) cnt[q]++;
        for (int i = 0; i < NP; i++) if (en && cnt[i] >= lim) fl[i] = 1'b1;
        repeat (2) @(posedge clk_in);
        #1 chk("parity_flag", 32'(fl), 32'(pflag));
    endtask : perr_step
    task automatic pin_try(input int w, input int sel, input logic e, output int first);
        logic low;
        low = 1'b0;
        first = -1;
        for (int k = 0; k < 30; k++) begin
            @(posedge clk_in);
            if (sel == 0) scl <= (k >= w);
            else sda <= (k >= w);
            #1 if ((sel == 0 ? scl_f : sda_f) === 1'b0 && !low) begin
                low = 1'b1;
                first = k;
            end
        end
        chk("pin_low_seen", 32'(e), 32'(low));
    endtask : pin_try
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_in = 1'b1;
        req = '0;
        en = 1'b0;
        perr = '0;
        pclr = '0;
        scl = 1'b1;
        sda = 1'b1;
        fl = '0;
        void'($urandom(89846));
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        m[5] = 8'h01;
        m[6] = 8'h00;
        m[7] = 8'hFE;
        m[8] = 8'h1C;
        for (int a = 4; a <= 9; a++) rd(8'(a));
        $display("test reset values done");
        for (int i = 0; i < 12; i++) begin
            t = 5 + $urandom % 4;
            d = 8'($urandom);
            if (t == 7 && d[7:1] == 7'h00) d[1] = 1'b1;
            if (t == 8) d[7] = 1'b0;
            wr(8'(t), d, 1'($urandom % 2));
            rd(8'(t));
        end
        $display("test read write done");
        wr(8'h08, 8'h9C, 1'b0);
        wr(8'h06, 8'($urandom), 1'b1);
        rd(8'h06);
        r = '{1'b1, 1'b0, 1'b1, 8'($urandom), 8'($urandom)};
        i_lecc_remote_model.target(r);
        #1 chk("tgt_req", 32'(r), 32'(tgt_out));
        wr(8'h08, 8'h00, 1'b1);
        wr(8'h08, 8'h1C, 1'b0);
        wr(8'h06, 8'($urandom), 1'b1);
        rd(8'h06);
        $display("test remote block done");
        lim = 2 + $urandom % 4;
        wr(8'h05, 8'h00, 1'b0);
        wr(8'h06, 8'(lim), 1'b0);
        p = $urandom % NP;
        for (int i = 0; i < 2 * lim; i++) begin
            @(posedge clk_in);
            en <= (i >= lim);
            perr_step(p, 1'b0);
        end
        perr_step(p, 1'b1);
        perr_step(p, 1'b0);
        wr(8'h06, 8'h01, 1'b0);
        lim = 1;
        perr_step((p + 1) % NP, 1'b0);
        $display("test parity done");
        wr(8'h07, 8'hFE, 1'b0);
        i_lecc_remote_model.run(0, 0, seen);
        chk("abort_cycle", 127 * TK + 1, seen);
        t = 1 + $urandom % 8;
        wr(8'h07, {t[6:0], 1'b0}, 1'b0);
        i_lecc_remote_model.run(0, 0, seen);
        chk("abort_cycle", t * TK + 1, seen);
        i_lecc_remote_model.run(t * TK / 2, 0, seen);
        chk("abort_cycle", -1, seen);
        i_lecc_remote_model.run(0, 3, seen);
        chk("abort_cycle", 3 + t * TK + 1, seen);
        wr(8'h07, {t[6:0], 1'b1}, 1'b0);
        i_lecc_remote_model.run(0, 0, seen);
        chk("abort_cycle", -1, seen);
        $display("test watchdog done");
        for (int s = 0; s < 2; s++) begin
            pin_try(2, s, 1'b0, f[s]);
            pin_try(3, s, 1'b0, f[s]);
            pin_try(4, s, 1'b1, f[s]);
            pin_try(12, s, 1'b1, f[s]);
        end
        chk("sda_hold_cycles", (m[8][6:4] * 50 + 19) / 20, f[1] - f[0]);
        wr(8'h08, 8'h00, 1'b0);
        for (int s = 0; s < 2; s++) pin_try(2, s, 1'b1, f[s]);
        chk("sda_hold_cycles", (m[8][6:4] * 50 + 19) / 20, f[1] - f[0]);
        $display("test pin filter done");
        stop_test();
    end
endmodule : testbench
